// >>> common/uart_lsr_regs.vh
// register map, field positions, reset values and timing counts
`ifndef UART_LSR_REGS_VH
`define UART_LSR_REGS_VH

`define OFS_TX_HOLDING 12'h000
`define OFS_LINE_STATUS 12'h004
`define OFS_FIFO_CONTROL 12'h008
`define OFS_BIT_DIVISOR 12'h00C
`define OFS_IRQ_STATUS 12'h010
`define OFS_IRQ_MASK 12'h014
`define OFS_CARD_CONTROL 12'h018

`define LSR_BREAK_BIT 4
`define LSR_TX_HOLDING_EMPTY_FLAG_BIT 5
`define LSR_TX_ALL_EMPTY_FLAG_BIT 6
`define LSR_RX_FIFO_ERROR_SUMMARY_BIT 7
`define LSR_CARD_TX_ERROR_FLAG_BIT 8

`define FCR_FIFO_EN_BIT 0
`define CARD_MODE_BIT 0
`define CARD_RETRY_LSB 1
`define CARD_RETRY_W 3

`define IRQ_BREAK_BIT 0
`define IRQ_TX_HOLDING_EMPTY_FLAG_BIT 1
`define IRQ_RX_FIFO_ERROR_SUMMARY_BIT 2
`define IRQ_CARD_TX_ERROR_FLAG_BIT 3
`define IRQ_W 4

`define DIVISOR_RESET 16'h006C
`define CHAR_BITS_RESET 4'h0A
`define RX_FIFO_DEPTH 16

`endif

// >>> src/break_detector.v
// counts whole bit times of a low receive line and flags a break
`timescale 1ns/1ps
module break_detector #(
	parameter CHAR_BITS = 10
) (
	input wire clk_sys,
	input wire srst,
	input wire bit_tick,
	input wire rx_in,
	output reg break_pulse_ff,
	output reg hold_idle_ff
);

	reg [4:0] low_cnt_ff;
	reg [4:0] nxt_low_cnt;

	always @* begin
		nxt_low_cnt = low_cnt_ff;
		if (rx_in || hold_idle_ff) begin
			nxt_low_cnt = 5'h00;
		end else if (bit_tick) begin
			nxt_low_cnt = low_cnt_ff + 5'h01;
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			low_cnt_ff <= 5'h00;
			break_pulse_ff <= 1'b0;
			hold_idle_ff <= 1'b0;
		end else begin
			low_cnt_ff <= nxt_low_cnt;
			break_pulse_ff <= 1'b0;
			// start, data, parity and stop all spent low
			if (!hold_idle_ff && !rx_in && bit_tick && nxt_low_cnt == CHAR_BITS[4:0]) begin
				break_pulse_ff <= 1'b1;
				hold_idle_ff <= 1'b1;
			end else if (hold_idle_ff && rx_in) begin
				hold_idle_ff <= 1'b0;
			end
		end
	end

endmodule

// >>> src/rx_err_fifo.v
// per-character error tags that follow the receive fifo entries
`timescale 1ns/1ps
module rx_err_fifo #(
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_sys,
	input wire srst,
	input wire push,
	input wire push_err,
	input wire push_brk,
	input wire pop,
	output wire head_valid,
	output wire head_err,
	output wire head_brk,
	output reg head_load_ff,
	output wire errs_behind
);

	reg [1:0] tag_ff [0:DEPTH-1];
	reg [AW-1:0] rd_ff;
	reg [AW-1:0] wr_ff;
	reg [AW:0] cnt_ff;
	reg [DEPTH-1:0] bad_vec;
	integer i;

	wire full = (cnt_ff == DEPTH[AW:0]);
	wire do_pop = pop && (cnt_ff != {(AW+1){1'b0}});
	// a push into a full fifo is dropped unless a pop frees a slot in the same cycle, the overrun belongs elsewhere
	wire do_push = push && (!full || do_pop);

	assign head_valid = (cnt_ff != {(AW+1){1'b0}});
	assign head_err = head_valid && tag_ff[rd_ff][0];
	assign head_brk = head_valid && tag_ff[rd_ff][1];
	assign errs_behind = |bad_vec;

	always @* begin
		bad_vec = {DEPTH{1'b0}};
		for (i = 1; i < DEPTH; i = i + 1) begin
			if (i < cnt_ff) begin
				bad_vec[i] = |tag_ff[(rd_ff + i) % DEPTH];
			end
		end
	end

	always @(posedge clk_sys) begin
		if (srst) begin
			rd_ff <= {AW{1'b0}};
			wr_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			head_load_ff <= 1'b0;
			for (i = 0; i < DEPTH; i = i + 1) begin
				tag_ff[i] <= 2'b00;
			end
		end else begin
			if (do_push) begin
				tag_ff[wr_ff] <= {push_brk, push_err};
				wr_ff <= wr_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_pop) begin
				rd_ff <= rd_ff + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_push && !do_pop) begin
				cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
			end else if (do_pop && !do_push) begin
				cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
			end
			// a fresh character reached the head
			head_load_ff <= (do_pop && (cnt_ff > {{(AW-1){1'b0}}, 2'b01} || do_push)) ||
				(do_push && !head_valid);
		end
	end

endmodule

// >>> src/uart_line_status_upper.v
// upper line status flags with apb registers, break, tx empty and card error logic
//
// What this block does
// - a break is flagged when the receive line stays low for a whole character time.
// - after a break the receiver holds idle until the receive line is high again.
// - reading the line status word clears the break flag, which resets to zero.
// - with the fifo on, the break is reported with the character at the fifo head.
// - with the fifo on, break reporting follows the fifo head, with it off it is immediate.
// - holding empty (bit 5) sets once the holding register empties, clears on a write, resets to one.
// - all empty (bit 6) is high only while holding and shift registers are both empty, resets to one.
// - the error summary (bit 7) sets when a framing, parity or break character reaches the head.
// - a status read clears the error summary only when no later errored characters remain.
// - the error summary reads zero whenever the fifos are disabled.
// - in card mode the tx error flag (bit 8) sets on the nack one past the retry limit.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "uart_lsr_regs.vh"
module uart_line_status_upper #(
	parameter CHAR_BITS = 10,
	parameter FIFO_DEPTH = `RX_FIFO_DEPTH,
	parameter FIFO_AW = 4
) (
	input wire clk_sys,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_ff,
	output reg pready_ff,
	output reg pslverr_ff,
	input wire serial_rx_input,
	input wire rx_char_push,
	input wire rx_char_err,
	input wire rx_char_pop,
	output reg rx_hold_idle_ff,
	output reg [7:0] tx_holding_register,
	output reg tx_hold_valid_ff,
	input wire tx_shift_take,
	input wire tx_shift_busy,
	input wire card_nack,
	input wire card_char_done,
	output reg irq_ff
);

	reg [15:0] divisor_ff;
	reg [15:0] div_cnt_ff;
	reg bit_tick_ff;
	reg fifo_en_ff;
	reg card_mode_ff;
	reg [`CARD_RETRY_W-1:0] card_retry_limit;
	reg [`CARD_RETRY_W:0] nack_cnt_ff;
	reg break_seen_flag;
	reg rx_fifo_error_summary;
	reg card_tx_error_flag;
	reg tx_holding_empty_flag_prev_ff;
	reg [`IRQ_W-1:0] irq_stat_ff;
	reg [`IRQ_W-1:0] irq_mask_ff;
	reg [`IRQ_W-1:0] nxt_irq_stat;
	reg [31:0] nxt_rdata;
	reg nxt_err;

	wire brk_pulse;
	wire brk_idle;
	wire head_valid;
	wire head_err;
	wire head_brk;
	wire head_load;
	wire errs_behind;

	// completion is the second access cycle, pready comes from a flop
	wire acc = psel && penable && !pready_ff;
	wire done = psel && penable && pready_ff;
	wire wr_done = done && pwrite && !pslverr_ff;
	wire lsr_read = done && !pwrite && (paddr == `OFS_LINE_STATUS);

	wire tx_holding_empty_flag = !tx_hold_valid_ff;
	wire tx_all_empty_flag = !tx_hold_valid_ff && !tx_shift_busy;

	wire thr_write = wr_done && (paddr == `OFS_TX_HOLDING);
	wire brk_event = fifo_en_ff ? (head_load && head_brk) : brk_pulse;
	wire err_head_event = head_load && (head_err || head_brk);
	wire card_tx_error_flag_event = card_mode_ff && card_nack &&
		(nack_cnt_ff == {1'b0, card_retry_limit});
	wire tx_holding_empty_flag_event = tx_holding_empty_flag && !tx_holding_empty_flag_prev_ff;

	break_detector #(
		.CHAR_BITS(CHAR_BITS)
	) u_brk (
		.clk_sys(clk_sys),
		.srst(srst),
		.bit_tick(bit_tick_ff),
		.rx_in(serial_rx_input),
		.break_pulse_ff(brk_pulse),
		.hold_idle_ff(brk_idle)
	);

	// a detected break enters the fifo as an all-zero character with its tag
	rx_err_fifo #(
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_tags (
		.clk_sys(clk_sys),
		.srst(srst),
		.push(fifo_en_ff && (rx_char_push || brk_pulse)),
		.push_err(rx_char_err && !brk_pulse),
		.push_brk(brk_pulse),
		.pop(fifo_en_ff && rx_char_pop),
		.head_valid(head_valid),
		.head_err(head_err),
		.head_brk(head_brk),
		.head_load_ff(head_load),
		.errs_behind(errs_behind)
	);

	// bit time divider, one tick per received bit period
	always @(posedge clk_sys) begin
		if (srst) begin
			div_cnt_ff <= 16'h0000;
			bit_tick_ff <= 1'b0;
		end else if (div_cnt_ff >= divisor_ff - 16'h0001) begin
			div_cnt_ff <= 16'h0000;
			bit_tick_ff <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 16'h0001;
			bit_tick_ff <= 1'b0;
		end
	end

	always @* begin
		nxt_rdata = 32'h0000_0000;
		nxt_err = 1'b0;
		case (paddr)
		`OFS_TX_HOLDING: begin
			nxt_rdata = 32'h0000_0000;
		end
		`OFS_LINE_STATUS: begin
			// bits 31..9 stay zero
			nxt_rdata[`LSR_BREAK_BIT] = break_seen_flag;
			nxt_rdata[`LSR_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
			nxt_rdata[`LSR_TX_ALL_EMPTY_FLAG_BIT] = tx_all_empty_flag;
			nxt_rdata[`LSR_RX_FIFO_ERROR_SUMMARY_BIT] = rx_fifo_error_summary && fifo_en_ff;
			nxt_rdata[`LSR_CARD_TX_ERROR_FLAG_BIT] = card_tx_error_flag;
		end
		`OFS_FIFO_CONTROL: begin
			nxt_rdata[`FCR_FIFO_EN_BIT] = fifo_en_ff;
		end
		`OFS_BIT_DIVISOR: begin
			nxt_rdata[15:0] = divisor_ff;
		end
		`OFS_IRQ_STATUS: begin
			nxt_rdata[`IRQ_W-1:0] = irq_stat_ff;
		end
		`OFS_IRQ_MASK: begin
			nxt_rdata[`IRQ_W-1:0] = irq_mask_ff;
		end
		`OFS_CARD_CONTROL: begin
			nxt_rdata[`CARD_MODE_BIT] = card_mode_ff;
			nxt_rdata[`CARD_RETRY_LSB +: `CARD_RETRY_W] = card_retry_limit;
		end
		default: begin
			nxt_err = 1'b1;
		end
		endcase
	end

	// apb slave: answer registered, unmapped addresses give pslverr
	always @(posedge clk_sys) begin
		if (srst) begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (acc) begin
			pready_ff <= 1'b1;
			prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
			pslverr_ff <= nxt_err;
		end else begin
			pready_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
	end

	// control registers; the line status word ignores writes
	always @(posedge clk_sys) begin
		if (srst) begin
			fifo_en_ff <= 1'b0;
			divisor_ff <= `DIVISOR_RESET;
			irq_mask_ff <= {`IRQ_W{1'b0}};
			card_mode_ff <= 1'b0;
			card_retry_limit <= {`CARD_RETRY_W{1'b0}};
		end else if (wr_done) begin
			case (paddr)
			`OFS_FIFO_CONTROL: begin
				fifo_en_ff <= pwdata[`FCR_FIFO_EN_BIT];
			end
			`OFS_BIT_DIVISOR: begin
				// zero would stall the tick, treat it as one
				divisor_ff <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
			end
			`OFS_IRQ_MASK: begin
				irq_mask_ff <= pwdata[`IRQ_W-1:0];
			end
			`OFS_CARD_CONTROL: begin
				card_mode_ff <= pwdata[`CARD_MODE_BIT];
				card_retry_limit <= pwdata[`CARD_RETRY_LSB +: `CARD_RETRY_W];
			end
			default: begin
				fifo_en_ff <= fifo_en_ff;
			end
			endcase
		end
	end

	// transmit holding register; a write while full overwrites the byte
	always @(posedge clk_sys) begin
		if (srst) begin
			tx_holding_register <= 8'h00;
			tx_hold_valid_ff <= 1'b0;
			tx_holding_empty_flag_prev_ff <= 1'b1;
		end else begin
			tx_holding_empty_flag_prev_ff <= tx_holding_empty_flag;
			if (thr_write) begin
				tx_holding_register <= pwdata[7:0];
				tx_hold_valid_ff <= 1'b1;
			end else if (tx_shift_take) begin
				tx_hold_valid_ff <= 1'b0;
			end
		end
	end

	// receive side status flags; a new event wins over a clearing read
	always @(posedge clk_sys) begin
		if (srst) begin
			break_seen_flag <= 1'b0;
			rx_fifo_error_summary <= 1'b0;
			rx_hold_idle_ff <= 1'b0;
		end else begin
			rx_hold_idle_ff <= brk_idle || brk_pulse;
			if (brk_event) begin
				break_seen_flag <= 1'b1;
			end else if (lsr_read) begin
				break_seen_flag <= 1'b0;
			end
			if (!fifo_en_ff) begin
				rx_fifo_error_summary <= 1'b0;
			end else if (err_head_event) begin
				rx_fifo_error_summary <= 1'b1;
			end else if (lsr_read && !errs_behind) begin
				rx_fifo_error_summary <= 1'b0;
			end
		end
	end

	// card retry counting: each nack is one rejection of the current character
	always @(posedge clk_sys) begin
		if (srst) begin
			nack_cnt_ff <= {(`CARD_RETRY_W+1){1'b0}};
			card_tx_error_flag <= 1'b0;
		end else begin
			if (card_char_done || !card_mode_ff) begin
				nack_cnt_ff <= {(`CARD_RETRY_W+1){1'b0}};
			end else if (card_nack && !(&nack_cnt_ff)) begin
				nack_cnt_ff <= nack_cnt_ff + {{`CARD_RETRY_W{1'b0}}, 1'b1};
			end
			if (card_tx_error_flag_event) begin
				card_tx_error_flag <= 1'b1;
			end else if (lsr_read) begin
				card_tx_error_flag <= 1'b0;
			end
		end
	end

	always @* begin
		nxt_irq_stat = irq_stat_ff;
		if (wr_done && paddr == `OFS_IRQ_STATUS) begin
			nxt_irq_stat = irq_stat_ff & ~pwdata[`IRQ_W-1:0];
		end
		if (brk_event) begin
			nxt_irq_stat[`IRQ_BREAK_BIT] = 1'b1;
		end
		if (tx_holding_empty_flag_event) begin
			nxt_irq_stat[`IRQ_TX_HOLDING_EMPTY_FLAG_BIT] = 1'b1;
		end
		if (err_head_event && fifo_en_ff) begin
			nxt_irq_stat[`IRQ_RX_FIFO_ERROR_SUMMARY_BIT] = 1'b1;
		end
		if (card_tx_error_flag_event) begin
			nxt_irq_stat[`IRQ_CARD_TX_ERROR_FLAG_BIT] = 1'b1;
		end
	end

	// sticky interrupt status, write one to clear, set wins
	always @(posedge clk_sys) begin
		if (srst) begin
			irq_stat_ff <= {`IRQ_W{1'b0}};
			irq_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

endmodule

// >>> testbench/uart_line_status_upper_properties.sv
// port checker for the upper line status block
`timescale 1ns/1ps
`include "uart_lsr_regs.vh"
module uart_lsr_checker (
	input wire clk_sys,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata_ff,
	input wire pready_ff,
	input wire pslverr_ff,
	input wire serial_rx_input,
	input wire rx_hold_idle_ff,
	input wire tx_hold_valid_ff,
	input wire tx_shift_take
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	pready_pulse_a: assert property (pready_ff |=> !pready_ff)
		else $error("ready longer than one cycle");
	ready_timing_a: assert property (psel && !penable |=> ##1 pready_ff)
		else $error("ready not in second access cycle");
	rdata_idle_a: assert property (!pready_ff |-> prdata_ff == 32'h0)
		else $error("read data outside ready");
	error_with_ready_a: assert property (pslverr_ff |-> pready_ff)
		else $error("error without ready");
	reserved_zero_a: assert property (
		pready_ff && !pwrite && paddr == `OFS_LINE_STATUS |-> prdata_ff[31:9] == 23'h0)
		else $error("reserved status bits set");
	write_fills_a: assert property (
		psel && penable && pready_ff && pwrite && paddr == `OFS_TX_HOLDING |=> tx_hold_valid_ff)
		else $error("holding not full after write");
	take_empties_a: assert property (
		tx_shift_take && !(psel && pwrite) |=> !tx_hold_valid_ff)
		else $error("holding still full after take");
	idle_holds_a: assert property (
		rx_hold_idle_ff && !serial_rx_input |=> rx_hold_idle_ff)
		else $error("receiver left idle while line low");
	idle_release_a: assert property (
		rx_hold_idle_ff && serial_rx_input |-> ##[1:4] !rx_hold_idle_ff)
		else $error("receiver stuck idle");
	break_cause_a: assert property (
		$rose(rx_hold_idle_ff) |-> !$past(serial_rx_input))
		else $error("break without low line");
endmodule
bind uart_line_status_upper uart_lsr_checker i_chk (.clk_sys(clk_sys), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_ff(prdata_ff),
	.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .serial_rx_input(serial_rx_input),
	.rx_hold_idle_ff(rx_hold_idle_ff), .tx_hold_valid_ff(tx_hold_valid_ff),
	.tx_shift_take(tx_shift_take));

// >>> testbench/tx_card_partner.sv
// far side: transmit shifter and a card that rejects on command
`timescale 1ns/1ps
module tx_card_partner (
	input wire clk_sys,
	input wire srst,
	input wire tx_hold_valid_ff,
	input wire stall,
	input wire [3:0] busy_len,
	input wire [3:0] nacks,
	output logic tx_shift_take,
	output logic tx_shift_busy,
	output logic card_nack,
	output logic card_char_done
);
	logic [3:0] cnt_ff;
	logic [3:0] left_ff;
	always @(posedge clk_sys) begin
		tx_shift_take <= 1'b0;
		card_nack <= 1'b0;
		card_char_done <= 1'b0;
		if (srst) begin
			tx_shift_busy <= 1'b0;
			cnt_ff <= 4'h0;
			left_ff <= 4'h0;
		end else if (tx_shift_busy) begin
			if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end else if (left_ff != 4'h0) begin
				// rejected char is resent, so stay busy
				card_nack <= 1'b1;
				left_ff <= left_ff - 4'h1;
				cnt_ff <= busy_len;
			end else begin
				tx_shift_busy <= 1'b0;
				card_char_done <= 1'b1;
			end
		end else if (tx_hold_valid_ff && !tx_shift_take && !stall) begin
			tx_shift_take <= 1'b1;
			tx_shift_busy <= 1'b1;
			cnt_ff <= busy_len;
			left_ff <= nacks;
		end
	end
endmodule

// >>> testbench/tb_uart_line_status_upper.sv
// self-checking bench for the upper line status flags
`timescale 1ns/1ps
`include "uart_lsr_regs.vh"
module tb_uart_line_status_upper;
	logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, stall = 0;
	logic serial_rx_input = 1, rx_char_push = 0, rx_char_err = 0, rx_char_pop = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, er, seed = 32'hb7e8_7fa4;
	logic [3:0] busy_len = 4'hf, nacks = 4'h0;
	logic [7:0] b;
	logic [2:0] lim;
	wire [31:0] prdata_ff;
	wire [7:0] tx_holding_register;
	wire pready_ff, pslverr_ff, rx_hold_idle_ff, tx_hold_valid_ff, irq_ff;
	wire tx_shift_take, tx_shift_busy, card_nack, card_char_done;
	int mismatches = 0, tests_run = 0;
	uart_line_status_upper i_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.serial_rx_input(serial_rx_input), .rx_char_push(rx_char_push),
		.rx_char_err(rx_char_err), .rx_char_pop(rx_char_pop), .rx_hold_idle_ff(rx_hold_idle_ff),
		.tx_holding_register(tx_holding_register), .tx_hold_valid_ff(tx_hold_valid_ff),
		.tx_shift_take(tx_shift_take), .tx_shift_busy(tx_shift_busy), .card_nack(card_nack),
		.card_char_done(card_char_done), .irq_ff(irq_ff));
	tx_card_partner i_far (.clk_sys(clk_sys), .srst(srst), .tx_hold_valid_ff(tx_hold_valid_ff),
		.stall(stall), .busy_len(busy_len), .nacks(nacks), .tx_shift_take(tx_shift_take),
		.tx_shift_busy(tx_shift_busy), .card_nack(card_nack), .card_char_done(card_char_done));
	always #2.5 clk_sys = ~clk_sys;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// look at ready mid-cycle, where the registered answer has settled
		do @(negedge clk_sys); while (pready_ff !== 1'b1 && n++ < 50);
		rd = prdata_ff;
		er = {31'h0, pslverr_ff};
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task rdl(input logic [31:0] e);
		apb(1'b0, `OFS_LINE_STATUS, 32'h0);
		chk(rd, e);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task txidle;
		int n;
		n = 0;
		while ((tx_shift_busy | tx_hold_valid_ff) !== 1'b0 && n++ < 400) @(posedge clk_sys);
	endtask
	task pop;
		rx_char_pop <= 1'b1;
		@(posedge clk_sys);
		rx_char_pop <= 1'b0;
		wt(3);
	endtask
	task brk;
		int n;
		n = 0;
		serial_rx_input <= 1'b0;
		wt(16);
		chk(rx_hold_idle_ff, 32'h0);
		while (rx_hold_idle_ff !== 1'b1 && n++ < 200) @(posedge clk_sys);
		chk(rx_hold_idle_ff, 32'h1);
		wt(4);
		chk(rx_hold_idle_ff, 32'h1);
		serial_rx_input <= 1'b1;
		wt(6);
		chk(rx_hold_idle_ff, 32'h0);
	endtask
	function logic [31:0] lsr(input logic bk, input logic fe, input logic te);
		return {23'h0, te, fe, 2'b11, bk, 4'h0};
	endfunction
	initial begin
		wt(6);
		srst <= 1'b0;
		wt(1);
		rdl(lsr(0, 0, 0));
		apb(1'b1, `OFS_LINE_STATUS, 32'hffff_ffff);
		rdl(lsr(0, 0, 0));
		apb(1'b0, 12'h020, 32'h0);
		chk(er, 32'h1);
		apb(1'b1, `OFS_BIT_DIVISOR, 32'h2);
		apb(1'b1, `OFS_IRQ_MASK, 32'h2);
		// stalled shifter keeps the holding register full
		stall <= 1'b1;
		b = $random(seed);
		apb(1'b1, `OFS_TX_HOLDING, {24'h0, b});
		chk({24'h0, tx_holding_register}, {24'h0, b});
		rdl(32'h0);
		chk(irq_ff, 32'h0);
		stall <= 1'b0;
		txidle;
		wt(2);
		chk(irq_ff, 32'h1);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
		chk(rd, 32'h2);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0);
		wt(2);
		chk(irq_ff, 32'h0);
		apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
		apb(1'b1, `OFS_IRQ_MASK, 32'h2);
		wt(2);
		chk(irq_ff, 32'h0);
		apb(1'b1, `OFS_TX_HOLDING, 32'h5a);
		rdl(32'h20);
		txidle;
		brk;
		rdl(lsr(1, 0, 0));
		rdl(lsr(0, 0, 0));
		apb(1'b1, `OFS_FIFO_CONTROL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			rx_char_push <= 1'b1;
			rx_char_err <= (i != 0);
			@(posedge clk_sys);
		end
		rx_char_push <= 1'b0;
		wt(3);
		rdl(lsr(0, 0, 0));
		pop;
		rdl(lsr(0, 1, 0));
		rdl(lsr(0, 1, 0));
		pop;
		rdl(lsr(0, 1, 0));
		rdl(lsr(0, 0, 0));
		pop;
		rx_char_push <= 1'b1;
		rx_char_err <= 1'b0;
		@(posedge clk_sys);
		rx_char_push <= 1'b0;
		brk;
		rdl(lsr(0, 0, 0));
		pop;
		rdl(lsr(1, 1, 0));
		rdl(lsr(0, 0, 0));
		pop;
		lim = $random(seed);
		apb(1'b1, `OFS_CARD_CONTROL, {28'h0, lim, 1'b1});
		for (int k = 0; k < 2; k++) begin
			nacks <= {1'b0, lim} + k[3:0];
			b = $random(seed);
			apb(1'b1, `OFS_TX_HOLDING, {24'h0, b});
			txidle;
			rdl(lsr(0, 0, k == 1));
		end
		rdl(lsr(0, 0, 0));
		conclude;
	end
	// whole run is under a thousand cycles; 40000 cycles means a hang
	initial begin
		#200000;
		mismatches++;
		conclude;
	end
endmodule
